/* File: logic/dbs_sequencer.v */
// Enable sequencer for two step-down regulators and two general outputs.
// Assumes all inputs synchronous to clk; analog comparators sit outside.
`timescale 1ns/1ns
`include "dbs_defines.vh"

module dbs_sequencer #(
    parameter DLY_STEP_CYCLES = `DBS_DLY_STEP_CYC,
    parameter SC_CYCLES = `DBS_SC_CYCLES,
    parameter BOOT_CYCLES = `DBS_BOOT_CYCLES,
    parameter RAMP_UNIT = `DBS_RAMP_UNIT,
    parameter [0:0] OTP_RESET_MASK = 1'b0
) (
    // Clock, reset, clock enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    // Pins and analog comparators
    input wire enablePin,
    input wire analogSupplyOk,
    input wire [1:0] outAboveSc,
    input wire [1:0] outUnderOk,
    input wire [1:0] outOverOk,
    // Regulator controls
    output reg [1:0] regOn,
    output reg [7:0] regVoltage0,
    output reg [7:0] regVoltage1,
    output reg [1:0] regSoftStart,
    output reg [1:0] regFixedFreq,
    // General outputs, pulldown, interrupt
    output reg generalOutA,
    output reg generalOutB,
    output reg enablePulldownOn,
    output reg irqLineN
);

    localparam ST_BOOT = 2'h0;
    localparam ST_STANDBY = 2'h1;
    localparam ST_ACTIVE = 2'h2;

    // ********************************
    // Register file
    // ********************************
    reg [7:0] ctrl0_reg;
    reg [7:0] ctrl1_reg;
    reg [7:0] vout0_reg;
    reg [7:0] vout1_reg;
    reg [7:0] dly0_reg;
    reg [7:0] dly1_reg;
    reg [7:0] goCtrl_reg;
    reg [7:0] goDlyA_reg;
    reg [7:0] goDlyB_reg;
    reg [7:0] config_reg;
    reg [3:0] mask_reg;
    reg resetMask_reg;
    reg [4:0] intFlags_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] bootCnt_reg;
    reg resetPending_reg;
    reg [1:0] pgPrev_reg;
    reg [7:0] rdNext;

    wire softReset;
    wire cfgClr;
    wire [1:0] pgLive;
    wire [1:0] scTrip;
    wire [3:0] chOn;
    wire [3:0] chPin;
    wire [15:0] chRise;
    wire [15:0] chFall;
    wire [3:0] pinDelayed;
    wire [3:0] chWant;
    wire [4:0] flagSet;
    wire [4:0] flagClr;
    wire running;

    assign softReset = ce & regWr & (regAddr == `DBS_ADDR_RESET) &
        regWdata[`DBS_RESET_TRIG];
    assign cfgClr = rst | softReset | ~analogSupplyOk;
    assign running = (state_reg == ST_STANDBY) | (state_reg == ST_ACTIVE);

    always @(posedge clk) begin
        if (cfgClr) begin
            ctrl0_reg <= `DBS_RST_CTRL;
            ctrl1_reg <= `DBS_RST_CTRL;
            vout0_reg <= `DBS_RST_VOUT;
            vout1_reg <= `DBS_RST_VOUT;
            dly0_reg <= `DBS_RST_DLY;
            dly1_reg <= `DBS_RST_DLY;
            goCtrl_reg <= `DBS_RST_GOCTRL;
            goDlyA_reg <= `DBS_RST_DLY;
            goDlyB_reg <= `DBS_RST_DLY;
            config_reg <= `DBS_RST_CONFIG;
            mask_reg <= `DBS_RST_MASK;
        end else if (ce && regWr) begin
            case (regAddr)
                `DBS_ADDR_CTRL0: ctrl0_reg <= regWdata;
                `DBS_ADDR_CTRL1: ctrl1_reg <= regWdata;
                `DBS_ADDR_VOUT0: vout0_reg <= regWdata;
                `DBS_ADDR_VOUT1: vout1_reg <= regWdata;
                `DBS_ADDR_DLY0: dly0_reg <= regWdata;
                `DBS_ADDR_DLY1: dly1_reg <= regWdata;
                `DBS_ADDR_GOCTRL: goCtrl_reg <= regWdata;
                `DBS_ADDR_GODLYA: goDlyA_reg <= regWdata;
                `DBS_ADDR_GODLYB: goDlyB_reg <= regWdata;
                `DBS_ADDR_CONFIG: config_reg <= regWdata;
                `DBS_ADDR_MASK: mask_reg <= regWdata[3:0];
                default: ;
            endcase
        end
    end

    // ********************************
    // Device state and start-up
    // ********************************
    always @* begin
        case (state_reg)
            ST_BOOT: state_next = (bootCnt_reg >= BOOT_CYCLES[7:0]) ? ST_STANDBY : ST_BOOT;
            ST_STANDBY: state_next = (|regOn) ? ST_ACTIVE : ST_STANDBY;
            ST_ACTIVE: state_next = (|regOn) ? ST_ACTIVE : ST_STANDBY;
            default: state_next = ST_BOOT;
        endcase
    end

    always @(posedge clk) begin
        if (cfgClr) begin
            state_reg <= ST_BOOT;
            bootCnt_reg <= 8'h00;
            resetMask_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            if (state_reg == ST_BOOT) begin
                bootCnt_reg <= bootCnt_reg + 8'h01;
                resetMask_reg <= OTP_RESET_MASK;
            end
        end
    end

    // Survives soft reset and undervoltage so the next start-up can report it
    always @(posedge clk) begin
        if (rst) begin
            resetPending_reg <= 1'b1;
        end else if (ce) begin
            if (softReset || !analogSupplyOk) begin
                resetPending_reg <= 1'b1;
            end else if (state_reg == ST_BOOT && state_next == ST_STANDBY) begin
                resetPending_reg <= 1'b0;
            end
        end
    end

    // ********************************
    // Pin delay channels: 0,1 regulators, 2,3 general outputs
    // ********************************
    assign chOn = {goCtrl_reg[2], goCtrl_reg[0], ctrl1_reg[`DBS_CTRL_ON],
        ctrl0_reg[`DBS_CTRL_ON]};
    assign chPin = {goCtrl_reg[3], goCtrl_reg[1], ctrl1_reg[`DBS_CTRL_PIN],
        ctrl0_reg[`DBS_CTRL_PIN]};
    assign chRise = {goDlyB_reg[3:0], goDlyA_reg[3:0], dly1_reg[3:0], dly0_reg[3:0]};
    assign chFall = {goDlyB_reg[7:4], goDlyA_reg[7:4], dly1_reg[7:4], dly0_reg[7:4]};

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : gChan
            reg pinDly_reg;
            reg [31:0] dlyCnt_reg;
            wire [3:0] code;
            wire [31:0] target;
            assign code = enablePin ? chRise[ch*4 +: 4] : chFall[ch*4 +: 4];
            assign target = {28'h0000000, code} * DLY_STEP_CYCLES;
            always @(posedge clk) begin
                if (cfgClr) begin
                    pinDly_reg <= 1'b0;
                    dlyCnt_reg <= 32'h00000000;
                end else if (ce) begin
                    if (enablePin == pinDly_reg) begin
                        dlyCnt_reg <= 32'h00000000;
                    end else if (dlyCnt_reg + 32'h00000001 >= target) begin
                        pinDly_reg <= enablePin;
                        dlyCnt_reg <= 32'h00000000;
                    end else begin
                        dlyCnt_reg <= dlyCnt_reg + 32'h00000001;
                    end
                end
            end
            assign pinDelayed[ch] = pinDly_reg | (enablePin & (code == 4'h0));
            assign chWant[ch] = chOn[ch] & (~chPin[ch] | pinDelayed[ch]);
        end
    endgenerate

    // ********************************
    // Regulator control, short circuit, ramp
    // ********************************
    genvar rg;
    generate
        for (rg = 0; rg < 2; rg = rg + 1) begin : gReg
            reg tripped_reg;
            reg [31:0] scCnt_reg;
            reg [7:0] ramp_reg;
            reg [15:0] rampCnt_reg;
            wire [7:0] ctrl;
            wire [7:0] vset;
            wire [15:0] interval;
            assign ctrl = rg ? ctrl1_reg : ctrl0_reg;
            assign vset = rg ? vout1_reg : vout0_reg;
            assign interval = RAMP_UNIT[15:0] <<
                ctrl[`DBS_CTRL_RATE_HI:`DBS_CTRL_RATE_LO];
            assign scTrip[rg] = regOn[rg] & ~outAboveSc[rg] &
                (scCnt_reg + 32'h00000001 >= SC_CYCLES);
            always @(posedge clk) begin
                if (cfgClr) begin
                    regOn[rg] <= 1'b0;
                    tripped_reg <= 1'b0;
                    scCnt_reg <= 32'h00000000;
                    ramp_reg <= 8'h00;
                    rampCnt_reg <= 16'h0000;
                    regSoftStart[rg] <= 1'b0;
                    regFixedFreq[rg] <= 1'b0;
                end else if (ce) begin
                    if (!chWant[rg]) begin
                        tripped_reg <= 1'b0;
                    end else if (scTrip[rg]) begin
                        tripped_reg <= 1'b1;
                    end
                    regOn[rg] <= chWant[rg] & running & ~tripped_reg &
                        ~scTrip[rg];
                    if (regOn[rg] && !outAboveSc[rg] && !scTrip[rg]) begin
                        scCnt_reg <= scCnt_reg + 32'h00000001;
                    end else begin
                        scCnt_reg <= 32'h00000000;
                    end
                    regSoftStart[rg] <= regOn[rg] & ~outAboveSc[rg];
                    if (!regOn[rg] || !outAboveSc[rg]) begin
                        ramp_reg <= 8'h00;
                        rampCnt_reg <= 16'h0000;
                    end else if (ramp_reg != vset) begin
                        if (rampCnt_reg + 16'h0001 >= interval) begin
                            rampCnt_reg <= 16'h0000;
                            ramp_reg <= (ramp_reg < vset) ? ramp_reg + 8'h01
                                : ramp_reg - 8'h01;
                        end else begin
                            rampCnt_reg <= rampCnt_reg + 16'h0001;
                        end
                    end
                    regFixedFreq[rg] <= ctrl[`DBS_CTRL_FPWM] |
                        (regOn[rg] & outAboveSc[rg] & (ramp_reg != vset));
                end
            end
            assign pgLive[rg] = regOn[rg] & outUnderOk[rg] &
                (~config_reg[`DBS_CFG_WINDOW] | outOverOk[rg]);
            // Code reads zero whenever the output sits below the short threshold
            wire [7:0] codeOut;
            assign codeOut = (regOn[rg] & outAboveSc[rg]) ? ramp_reg : 8'h00;
            if (rg == 0) begin : gOut0
                always @(posedge clk) begin
                    if (cfgClr) begin
                        regVoltage0 <= 8'h00;
                    end else if (ce) begin
                        regVoltage0 <= codeOut;
                    end
                end
            end else begin : gOut1
                always @(posedge clk) begin
                    if (cfgClr) begin
                        regVoltage1 <= 8'h00;
                    end else if (ce) begin
                        regVoltage1 <= codeOut;
                    end
                end
            end
        end
    endgenerate

    // ********************************
    // General outputs and pulldown
    // ********************************
    always @(posedge clk) begin
        if (cfgClr) begin
            generalOutA <= 1'b0;
            generalOutB <= 1'b0;
            enablePulldownOn <= 1'b0;
        end else if (ce) begin
            generalOutA <= chWant[2] & running;
            generalOutB <= chWant[3] & running;
            enablePulldownOn <= config_reg[`DBS_CFG_PULLDOWN];
        end
    end

    // ********************************
    // Flags and interrupt line
    // ********************************
    assign flagSet[1:0] = scTrip;
    assign flagSet[3:2] = (pgLive & ~pgPrev_reg & ~mask_reg[1:0]) |
        (~pgLive & pgPrev_reg & ~mask_reg[3:2]);
    // Raised on the boot-to-standby step; the pending bit clears on that same edge
    assign flagSet[4] = resetPending_reg & ~resetMask_reg & (state_reg == ST_BOOT) &
        (state_next == ST_STANDBY);
    assign flagClr = (regWr && regAddr == `DBS_ADDR_INT) ? regWdata[4:0] : 5'h00;

    always @(posedge clk) begin
        if (cfgClr) begin
            intFlags_reg <= 5'h00;
            pgPrev_reg <= 2'h0;
            irqLineN <= 1'b1;
        end else if (ce) begin
            pgPrev_reg <= pgLive;
            intFlags_reg <= (intFlags_reg & ~flagClr) | flagSet;
            irqLineN <= ~|((intFlags_reg & ~flagClr) | flagSet);
        end
    end

    // ********************************
    // Read port, reset only by rst
    // ********************************
    always @* begin
        case (regAddr)
            `DBS_ADDR_CTRL0: rdNext = ctrl0_reg;
            `DBS_ADDR_CTRL1: rdNext = ctrl1_reg;
            `DBS_ADDR_VOUT0: rdNext = vout0_reg;
            `DBS_ADDR_VOUT1: rdNext = vout1_reg;
            `DBS_ADDR_DLY0: rdNext = dly0_reg;
            `DBS_ADDR_DLY1: rdNext = dly1_reg;
            `DBS_ADDR_GOCTRL: rdNext = goCtrl_reg;
            `DBS_ADDR_GODLYA: rdNext = goDlyA_reg;
            `DBS_ADDR_GODLYB: rdNext = goDlyB_reg;
            `DBS_ADDR_CONFIG: rdNext = {6'h00, config_reg[1:0]};
            `DBS_ADDR_MASK: rdNext = {3'h0, resetMask_reg, mask_reg};
            `DBS_ADDR_INT: rdNext = {3'h0, intFlags_reg};
            `DBS_ADDR_STAT: rdNext = {2'h0, state_reg, regOn, pgLive};
            default: rdNext = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (ce) begin
            regRdata <= regRd ? rdNext : 8'h00;
        end
    end

endmodule // dbs_sequencer

/* File: logic/dbs_defines.vh */
// Register map, field positions, reset values and timing for the sequencer.
// Assumes inclusion by bare name from logic/; definitions only.
`ifndef DBS_DEFINES_VH
`define DBS_DEFINES_VH
// ********************************
// Register offsets
// ********************************
`define DBS_ADDR_CTRL0   8'h00
`define DBS_ADDR_CTRL1   8'h01
`define DBS_ADDR_VOUT0   8'h02
`define DBS_ADDR_VOUT1   8'h03
`define DBS_ADDR_DLY0    8'h04
`define DBS_ADDR_DLY1    8'h05
`define DBS_ADDR_GOCTRL  8'h06
`define DBS_ADDR_GODLYA  8'h07
`define DBS_ADDR_GODLYB  8'h08
`define DBS_ADDR_CONFIG  8'h09
`define DBS_ADDR_MASK    8'h0A
`define DBS_ADDR_INT     8'h0B
`define DBS_ADDR_STAT    8'h0C
`define DBS_ADDR_RESET   8'h0D
// ********************************
// Field positions
// ********************************
`define DBS_CTRL_ON      0
`define DBS_CTRL_PIN     1
`define DBS_CTRL_FPWM    2
`define DBS_CTRL_RATE_LO 3
`define DBS_CTRL_RATE_HI 5
`define DBS_CFG_PULLDOWN 0
`define DBS_CFG_WINDOW   1
`define DBS_MASK_RESET   4
`define DBS_INT_RESET    4
`define DBS_RESET_TRIG   0
// ********************************
// Reset values
// ********************************
`define DBS_RST_CTRL     8'h00
`define DBS_RST_VOUT     8'h80
`define DBS_RST_DLY      8'h00
`define DBS_RST_GOCTRL   8'h00
`define DBS_RST_CONFIG   8'h01
`define DBS_RST_MASK     4'h0
// ********************************
// Timing
// ********************************
`define DBS_CLK_KHZ      10000
`define DBS_SC_TIME_US   1000
`define DBS_SC_CYCLES    ((`DBS_SC_TIME_US * `DBS_CLK_KHZ) / 1000)
`define DBS_DLY_STEP_US  1000
`define DBS_DLY_STEP_CYC ((`DBS_DLY_STEP_US * `DBS_CLK_KHZ) / 1000)
`define DBS_BOOT_CYCLES  4
`define DBS_RAMP_UNIT    8
`endif

/* File: tb/dbs_seq_chk.sv */
// Port assertions for dbs_sequencer.
// Assumes bind onto dbs_sequencer; one clock, synchronous reset.
`timescale 1ns/1ns
module dbs_seq_chk #(
    parameter SC_CYCLES = 20
) (
    // Clock and bus
    input wire clk, input wire rst, input wire ce,
    input wire [7:0] regAddr, input wire [7:0] regWdata,
    input wire regWr, input wire regRd, input wire [7:0] regRdata,
    // Analog side and outputs
    input wire analogSupplyOk, input wire [1:0] outAboveSc,
    input wire [1:0] regOn, input wire [7:0] regVoltage0,
    input wire [1:0] regSoftStart, input wire [1:0] regFixedFreq,
    input wire generalOutA, input wire generalOutB,
    input wire enablePulldownOn, input wire irqLineN
);
    // ***
    // Assertions
    // ***
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    reg [15:0] scCnt;
    wire softRst = ce && regWr && regAddr == 8'h0D && regWdata[0];
    wire allLow = regOn == 2'h0 && !generalOutA && !generalOutB;
    // Cycles on with the output held under the short threshold
    always @(posedge clk) begin
        if (rst || !regOn[0] || outAboveSc[0]) begin
            scCnt <= 16'h0000;
        end else if (ce) begin
            scCnt <= scCnt + 16'h0001;
        end
    end
    a_boot_holds_off: assert property ($fell(rst) || $rose(analogSupplyOk) |->
        (regOn == 2'h0) [*4]) else $error("regulator on during boot");
    a_short_trips: assert property (scCnt <= SC_CYCLES + 2)
        else $error("short not tripped");
    a_soft_rst_off: assert property (softRst |=> allLow)
        else $error("outputs on after soft reset");
    a_rst_bit_clear: assert property (softRst ##2 ce && regRd &&
        regAddr == 8'h0D |=> regRdata == 8'h00) else $error("reset bit not cleared");
    a_supply_low_off: assert property (ce && !analogSupplyOk |=> allLow)
        else $error("outputs on at supply low");
    a_reset_flag_irq: assert property (softRst |-> ##[2:20] !irqLineN)
        else $error("no reset flag interrupt");
    a_soft_start_zero: assert property (regSoftStart[0] |-> regVoltage0 == 8'h00)
        else $error("code nonzero in soft start");
    a_ramp_steps: assert property (regOn[0] && !regSoftStart[0] ##1 regOn[0] |->
        regSoftStart[0] || regVoltage0 == $past(regVoltage0) ||
        regVoltage0 == $past(regVoltage0) + 8'h01 || regVoltage0 == $past(regVoltage0) - 8'h01)
        else $error("abrupt voltage step");
    a_ramp_pwm: assert property (regOn[0] && $past(regOn[0]) && !regSoftStart[0] &&
        regVoltage0 != $past(regVoltage0) |-> regFixedFreq[0] || $past(regFixedFreq[0]))
        else $error("ramp without fixed frequency");
    a_pulldown_copy: assert property (ce && regWr && regAddr == 8'h09 |->
        ##2 enablePulldownOn == $past(regWdata[0], 2)) else $error("pulldown mismatch");
endmodule // dbs_seq_chk

bind dbs_sequencer dbs_seq_chk #(.SC_CYCLES(SC_CYCLES)) chk (.clk(clk), .rst(rst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .analogSupplyOk(analogSupplyOk), .outAboveSc(outAboveSc),
    .regOn(regOn), .regVoltage0(regVoltage0), .regSoftStart(regSoftStart),
    .regFixedFreq(regFixedFreq), .generalOutA(generalOutA), .generalOutB(generalOutB),
    .enablePulldownOn(enablePulldownOn), .irqLineN(irqLineN));

/* File: tb/dbs_plant_model.sv */
// Regulator plant: comparator levels derived from the enables and the fault controls.
// Assumes the bench drives shortCmd and overCmd as fault controls.
`timescale 1ns/1ns
module dbs_plant_model #(
    parameter RISE_CYCLES = 3
) (
    // Clock and enables
    input wire clk,
    input wire [1:0] regOn,
    // Faults
    input wire [1:0] shortCmd,
    input wire [1:0] overCmd,
    // Comparators
    output reg [1:0] outAboveSc = 2'h0,
    output reg [1:0] outUnderOk = 2'h0,
    output wire [1:0] outOverOk
);
    // ***
    // Output rises after enable; a short holds it at ground
    // ***
    reg [7:0] age [0:1];
    integer i;
    always @(posedge clk) begin
        for (i = 0; i < 2; i = i + 1) begin
            age[i] <= !regOn[i] ? 8'h00 : (age[i] == 8'hFF ? age[i] : age[i] + 8'h01);
            outAboveSc[i] <= regOn[i] && !shortCmd[i] && age[i] >= RISE_CYCLES;
            outUnderOk[i] <= regOn[i] && !shortCmd[i] && age[i] >= 2 * RISE_CYCLES;
        end
    end
    assign outOverOk = ~overCmd;
endmodule // dbs_plant_model

/* File: tb/dbs_sequencer_test.sv */
// Bench for dbs_sequencer: bus tasks, pin stimulus and plant model.
// Assumes logic/ on the include path and the checker bound in.
`timescale 1ns/1ns
`define CHK(g, e) begin checksDone = checksDone + 1; if ((g) !== (e)) begin \
    failCount = failCount + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dbs_sequencer_test;
    // ***
    // Signals and instances
    // ***
    reg clk = 1'b0, rst = 1'b1, ce = 1'b1, regWr = 1'b0, regRd = 1'b0;
    reg enablePin = 1'b0, analogSupplyOk = 1'b1;
    reg [7:0] regAddr = 8'h00, regWdata = 8'h00, rdv;
    reg [1:0] shortCmd = 2'h0, overCmd = 2'h0;
    wire [7:0] regRdata, regVoltage0, regVoltage1;
    wire [1:0] regOn, regSoftStart, regFixedFreq, outAboveSc, outUnderOk, outOverOk;
    wire generalOutA, generalOutB, enablePulldownOn, irqLineN;
    wire [3:0] outs = {generalOutB, generalOutA, regOn};
    wire [23:0] dlyMap = {8'h08, 8'h07, 8'h04};
    integer failCount = 0, checksDone = 0, seed = 32'hD366, cycles = 0, i, b, c, code;
    dbs_sequencer #(.DLY_STEP_CYCLES(4), .SC_CYCLES(20), .OTP_RESET_MASK(1'b0)) uut (
        .clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .enablePin(enablePin), .analogSupplyOk(analogSupplyOk), .outAboveSc(outAboveSc),
        .outUnderOk(outUnderOk), .outOverOk(outOverOk), .regOn(regOn),
        .regVoltage0(regVoltage0), .regVoltage1(regVoltage1), .regSoftStart(regSoftStart),
        .regFixedFreq(regFixedFreq), .generalOutA(generalOutA), .generalOutB(generalOutB),
        .enablePulldownOn(enablePulldownOn), .irqLineN(irqLineN));
    dbs_plant_model #(.RISE_CYCLES(3)) plant (.clk(clk), .regOn(regOn), .shortCmd(shortCmd),
        .overCmd(overCmd), .outAboveSc(outAboveSc), .outUnderOk(outUnderOk),
        .outOverOk(outOverOk));
    // ***
    // Tasks and expectations
    // ***
    task completeRun;
        if (failCount == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task rdChk(input [7:0] a, input [7:0] m, input [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdata & m;
        @(posedge clk);
        `CHK(rdv, e)
    endtask
    task idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task waitOut(input integer k, input v, output integer n);
        n = 0;
        while (outs[k] !== v && n < 1500) begin
            @(posedge clk);
            n = n + 1;
        end
    endtask
    task waitV(input [7:0] t, output integer n);
        n = 0;
        while (regVoltage1 !== t && n < 1500) begin
            @(posedge clk);
            n = n + 1;
        end
    endtask
    function [7:0] expRst(input [7:0] a);
        expRst = (a == 8'h02 || a == 8'h03) ? 8'h80 : (a == 8'h09 ? 8'h01 : 8'h00);
    endfunction
    function integer expDly(input integer n);
        expDly = n * 4;
    endfunction
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 8000) begin
            failCount = failCount + 1;
            completeRun;
        end
    end
    // ***
    // Scenarios
    // ***
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        idle(10);
        for (i = 0; i < 14; i = i + 1) begin
            if (i != 11 && i != 12) rdChk(i[7:0], 8'hFF, expRst(i[7:0]));
        end
        rdChk(8'h20, 8'hFF, 8'h00);
        `CHK(enablePulldownOn, 1'b1)
        rdChk(8'h0B, 8'h10, 8'h10);
        `CHK(irqLineN, 1'b0)
        wr(8'h0B, 8'h00);
        rdChk(8'h0B, 8'h10, 8'h10);
        wr(8'h0B, 8'h10);
        idle(2);
        `CHK(irqLineN, 1'b1)
        wr(8'h00, 8'h03);
        wr(8'h06, 8'h0F);
        for (i = 0; i < 6; i = i + 1) begin
            code = {$random(seed)} % 4;
            b = (i % 3 == 0) ? 0 : i % 3 + 1;
            wr(dlyMap[8 * (i % 3) +: 8], {code[3:0], 4'h3 - code[3:0]});
            enablePin <= 1'b1;
            waitOut(b, 1'b1, c);
            c = c - expDly(3 - code);
            `CHK(c > 0 && c < 5, 1'b1)
            enablePin <= 1'b0;
            waitOut(b, 1'b0, c);
            c = c - expDly(code);
            `CHK(c > 0 && c < 5, 1'b1)
            idle(16);
        end
        wr(8'h04, 8'hFF);
        wr(8'h00, 8'h01);
        waitOut(0, 1'b1, c);
        `CHK(c < 4, 1'b1)
        wr(8'h00, 8'h00);
        waitOut(0, 1'b0, c);
        `CHK(c < 4, 1'b1)
        shortCmd <= 2'h1;
        wr(8'h00, 8'h01);
        waitOut(0, 1'b1, c);
        waitOut(0, 1'b0, c);
        `CHK(c > 16 && c < 25, 1'b1)
        rdChk(8'h0B, 8'h01, 8'h01);
        wr(8'h00, 8'h00);
        shortCmd <= 2'h0;
        wr(8'h0B, 8'h1F);
        wr(8'h01, 8'h01);
        waitV(8'h80, c);
        `CHK(regVoltage1, 8'h80)
        idle(8);
        rdChk(8'h0C, 8'h02, 8'h02);
        rdChk(8'h0B, 8'h08, 8'h08);
        wr(8'h0B, 8'h1F);
        code = {$random(seed)} % 3;
        wr(8'h01, {2'h0, code[2:0], 3'h1});
        wr(8'h03, 8'h84);
        idle(1);
        `CHK(regFixedFreq[1], 1'b1)
        waitV(8'h84, c);
        `CHK(c > 3 * (8 << code) - 3 && c < 4 * (8 << code) + 5, 1'b1)
        idle(4);
        `CHK(regFixedFreq[1], 1'b0)
        wr(8'h09, 8'h00);
        idle(1);
        `CHK(enablePulldownOn, 1'b0)
        overCmd <= 2'h2;
        idle(3);
        rdChk(8'h0C, 8'h02, 8'h02);
        wr(8'h09, 8'h02);
        idle(3);
        rdChk(8'h0C, 8'h02, 8'h00);
        rdChk(8'h0B, 8'h08, 8'h08);
        `CHK(irqLineN, 1'b0)
        wr(8'h0B, 8'h08);
        idle(2);
        `CHK(irqLineN, 1'b1)
        wr(8'h0A, 8'h02);
        overCmd <= 2'h0;
        idle(3);
        rdChk(8'h0C, 8'h02, 8'h02);
        rdChk(8'h0B, 8'h08, 8'h00);
        wr(8'h0D, 8'h01);
        rdChk(8'h0D, 8'hFF, 8'h00);
        `CHK(outs, 4'h0)
        rdChk(8'h01, 8'hFF, 8'h00);
        idle(12);
        rdChk(8'h0B, 8'h10, 8'h10);
        wr(8'h0A, 8'h10);
        rdChk(8'h0A, 8'h10, 8'h00);
        wr(8'h0B, 8'h10);
        wr(8'h06, 8'h01);
        idle(3);
        analogSupplyOk <= 1'b0;
        idle(3);
        `CHK(outs, 4'h0)
        analogSupplyOk <= 1'b1;
        idle(1);
        wr(8'h00, 8'h01);
        `CHK(regOn[0], 1'b0)
        waitOut(0, 1'b1, c);
        `CHK(c < 10, 1'b1)
        rdChk(8'h06, 8'hFF, 8'h00);
        ce <= 1'b0;
        wr(8'h00, 8'h00);
        `CHK(regOn[0], 1'b1)
        ce <= 1'b1;
        rdChk(8'h00, 8'hFF, 8'h01);
        completeRun;
    end
endmodule // dbs_sequencer_test
